// [bench/fifo_side_model.sv]
// behavioural fifos and line side of the four channels
// assumes pop/push pulses are one cycle; bench never overfills a fifo
`timescale 1ns/10ps
`default_nettype none
module fifo_side_model (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [3:0] rxFifoPop,
    input wire logic [3:0] txFifoPush,
    input wire logic [3:0] rxInject,
    input wire logic txDrain,
    output logic [19:0] rxFifoCount,
    output logic [19:0] txFifoCount,
    output logic [31:0] rxFifoData,
    output logic [3:0] rxCharArrived
);
    logic [4:0] rc [4];
    logic [4:0] tc [4];
    logic tg;
    ////////////////////////////////////////////////////////////////////
    // counts only; tx fifos drain one byte per cycle while txDrain is high
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rc <= '{default: 5'h0};
            tc <= '{default: 5'h0};
            tg <= 1'b0;
        end else begin
            tg <= ~tg;
            for (int i = 0; i < 4; i++) begin
                rc[i] <= rc[i] + rxInject[i] - rxFifoPop[i];
                tc[i] <= tc[i] + txFifoPush[i]
                    - (txDrain && tc[i] != 5'h0);
            end
        end
    end
    // an empty fifo shows a toggling head, never a stale byte
    always @* begin
        for (int i = 0; i < 4; i++) begin
            rxFifoCount[i*5+:5] = rc[i];
            txFifoCount[i*5+:5] = tc[i];
            rxFifoData[i*8+:8] = rc[i] != 5'h0 ? {3'h1, rc[i]} : {8{tg}};
        end
    end
    assign rxCharArrived = rxInject;
endmodule // fifo_side_model
`default_nettype wire

// [bench/uart_dma_ready_props.sv]
// checker for reset state, register side effects and dma request pins
// assumes it is bound onto uart_dma_ready; one clock, async low reset
`timescale 1ns/10ps
`default_nettype none
module uart_dma_ready_props (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [4:0] addr,
    input wire logic [7:0] writeData,
    input wire logic writeStrobe,
    input wire logic readStrobe,
    input wire logic [7:0] readData,
    input wire logic [19:0] rxFifoCount,
    input wire logic [19:0] txFifoCount,
    input wire logic [3:0] rxFifoPop,
    input wire logic [3:0] txFifoPush,
    input wire logic [7:0] txPushData,
    input wire logic [3:0] channelEnable,
    input wire logic counterRestart,
    input wire logic [3:0] irqOut,
    input wire logic [3:0] dtrN,
    input wire logic [3:0] rtsN,
    input wire logic rxDmaRequestN,
    input wire logic txDmaRequestN
);
    // fill summaries; both modes agree on these cases, so no mode tracking
    wire logic allTxFull = txFifoCount == {4{5'h10}};
    wire logic allRxEmpty = rxFifoCount == 20'h0;
    wire logic anyTxEmpty = txFifoCount[4:0] == 5'h0
        || txFifoCount[9:5] == 5'h0 || txFifoCount[14:10] == 5'h0
        || txFifoCount[19:15] == 5'h0;
    ////////////////////////////////////////////////////////////////////
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    a_modem_reset_high: assert property (
        $rose(rstn) |-> dtrN == 4'hf && rtsN == 4'hf)
        else $error("modem outputs not inactive after reset");
    a_irq_reset_clear: assert property (
        $rose(rstn) |-> irqOut == 4'h0)
        else $error("interrupt pending straight after reset");
    a_restart_pulse: assert property (
        $rose(rstn) |-> counterRestart ##1 !counterRestart)
        else $error("counter restart pulse wrong");
    a_enable_cause: assert property (
        channelEnable != $past(channelEnable) |->
        $past(writeStrobe) && $past(addr[2:0]) == 3'h3)
        else $error("channel enabled without line control write");
    a_read_pop: assert property (
        readStrobe && addr[2:0] == 3'h0 |=>
        rxFifoPop == 4'h1 << $past(addr[4:3]))
        else $error("data read did not pop its fifo");
    a_write_push: assert property (
        writeStrobe && addr[2:0] == 3'h0 |=> txPushData == $past(writeData)
        && txFifoPush == 4'h1 << $past(addr[4:3]))
        else $error("data write did not push its fifo");
    a_read_idle_zero: assert property (
        !readStrobe |=> readData == 8'h00)
        else $error("read data outside the answer cycle");
    a_tx_full_high: assert property (
        allTxFull |=> txDmaRequestN)
        else $error("tx request low with all fifos full");
    a_tx_empty_low: assert property (
        anyTxEmpty |=> !txDmaRequestN)
        else $error("tx request high with an empty fifo");
    a_rx_empty_high: assert property (
        allRxEmpty [*2] |=> rxDmaRequestN)
        else $error("rx request low with all fifos empty");
endmodule // uart_dma_ready_props
bind uart_dma_ready uart_dma_ready_props chk (.clk, .rstn, .addr,
    .writeData, .writeStrobe, .readStrobe, .readData, .rxFifoCount,
    .txFifoCount, .rxFifoPop, .txFifoPush, .txPushData, .channelEnable,
    .counterRestart, .irqOut, .dtrN, .rtsN, .rxDmaRequestN, .txDmaRequestN);
`default_nettype wire

// [bench/uart_dma_ready_tb.sv]
// self-checking bench: register reads/writes, interrupts, dma pins
// assumes fifo_side_model stands in for fifos; shifter tied idle
`timescale 1ns/10ps
`default_nettype none
module uart_dma_ready_tb;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [4:0] addr = 5'h0;
    logic [7:0] writeData = 8'h0;
    logic writeStrobe = 1'b0;
    logic readStrobe = 1'b0;
    logic txDrain = 1'b0;
    logic [3:0] charTimeTick = 4'h0;
    logic [3:0] rxInject = 4'h0;
    logic [15:0] lineErrorEvent = 16'h0;
    logic [15:0] modemLevels = 16'h5a3c;
    logic [19:0] rxFifoCount, txFifoCount;
    logic [31:0] rxFifoData;
    logic [3:0] rxCharArrived, rxFifoPop, txFifoPush, channelEnable;
    logic [3:0] irqOut, dtrN, rtsN;
    logic [7:0] readData, txPushData, got;
    logic counterRestart, rxDmaRequestN, txDmaRequestN;
    int miscompares = 0;
    int samples_checked = 0;
    always #20 clk = ~clk;
    uart_dma_ready dut (.clk, .rstn, .addr, .writeData, .writeStrobe,
        .readStrobe, .readData, .rxFifoCount, .txFifoCount, .rxFifoData,
        .rxCharArrived, .charTimeTick, .lineErrorEvent, .txShifterBusy(4'h0),
        .modemLevels, .rxFifoPop, .txFifoPush, .txPushData, .channelEnable,
        .counterRestart, .irqOut, .dtrN, .rtsN, .rxDmaRequestN,
        .txDmaRequestN);
    fifo_side_model far (.clk, .rstn, .rxFifoPop, .txFifoPush, .rxInject,
        .txDrain, .rxFifoCount, .txFifoCount, .rxFifoData, .rxCharArrived);
    ////////////////////////////////////////////////////////////////////
    task automatic chk(string w, logic [7:0] e, logic [7:0] s);
        samples_checked++;
        if (s !== e) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", w, e, s);
        end
    endtask
    task automatic wr(int c, int i, logic [7:0] d);
        @(posedge clk);
        addr <= {c[1:0], i[2:0]};
        writeData <= d;
        writeStrobe <= 1'b1;
        @(posedge clk);
        writeStrobe <= 1'b0;
    endtask
    // read data is taken one settle step after the answer edge
    task automatic rc(string w, int c, int i, logic [7:0] e);
        @(posedge clk);
        addr <= {c[1:0], i[2:0]};
        readStrobe <= 1'b1;
        @(posedge clk);
        readStrobe <= 1'b0;
        #1 got = readData;
        chk(w, e, got);
    endtask
    task automatic cyc(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic inj(logic [3:0] m);
        @(posedge clk);
        rxInject <= m;
        @(posedge clk);
        rxInject <= 4'h0;
    endtask
    task automatic tick;
        @(posedge clk);
        charTimeTick <= 4'h4;
        @(posedge clk);
        charTimeTick <= 4'h0;
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        cyc(1);
        chk("modem pins", 8'hff, {dtrN, rtsN});
        chk("enable", 8'h0, {4'h0, channelEnable});
        for (int c = 0; c < 4; c++) begin
            rc("lstat", c, 5, 8'h60);
            rc("ienable", c, 1, 8'h00);
            rc("ident", c, 2, 8'h01);
            rc("lctrl", c, 3, 8'h00);
            rc("mctrl", c, 4, 8'h00);
            rc("mstat", c, 6, {modemLevels[c*4+:4], 4'h0});
        end
        $display("test reset done");
        wr(1, 7, 8'ha5);
        wr(2, 7, 8'h5a);
        wr(0, 5, 8'h00);
        rc("scratch1", 1, 7, 8'ha5);
        rc("scratch2", 2, 7, 8'h5a);
        rc("lstat", 0, 5, 8'h60);
        $display("test scratch done");
        wr(0, 3, 8'h03);
        cyc(1);
        chk("enable", 8'h01, {4'h0, channelEnable});
        rc("lctrl", 0, 3, 8'h03);
        wr(1, 4, 8'hff);
        rc("mctrl", 1, 4, 8'h1f);
        chk("modem pins", 8'hdd, {dtrN, rtsN});
        wr(0, 1, 8'hff);
        rc("ienable", 0, 1, 8'h0f);
        chk("irq", 8'h1, {7'h0, irqOut[0]});
        rc("ident", 0, 2, 8'h02);
        cyc(1);
        chk("irq", 8'h0, {7'h0, irqOut[0]});
        wr(0, 0, 8'h11);
        inj(4'h1);
        cyc(2);
        rc("ident", 0, 2, 8'h04);
        rc("rdata", 0, 0, 8'h21);
        cyc(3);
        chk("irq", 8'h0, {7'h0, irqOut[0]});
        lineErrorEvent <= 16'h0002;
        cyc(1);
        lineErrorEvent <= 16'h0;
        cyc(2);
        rc("ident", 0, 2, 8'h06);
        rc("lstat", 0, 5, 8'h04);
        cyc(1);
        chk("irq", 8'h0, {7'h0, irqOut[0]});
        modemLevels <= 16'h5a3d;
        cyc(3);
        rc("ident", 0, 2, 8'h00);
        rc("mstat", 0, 6, 8'hd1);
        cyc(1);
        chk("irq", 8'h0, {7'h0, irqOut[0]});
        $display("test interrupts done");
        // mode 0: pin high only when every channel holds a byte
        for (int c = 1; c < 4; c++)
            wr(c, 0, 8'h40);
        cyc(3);
        chk("txpin", 8'h1, {7'h0, txDmaRequestN});
        for (int n = 1; n < 16; n++)
            wr(0, 0, n[7:0]);
        txDrain <= 1'b1;
        cyc(20);
        txDrain <= 1'b0;
        chk("txpin", 8'h0, {7'h0, txDmaRequestN});
        chk("rxpin", 8'h1, {7'h0, rxDmaRequestN});
        inj(4'h4);
        cyc(3);
        chk("rxpin", 8'h0, {7'h0, rxDmaRequestN});
        rc("rdata2", 2, 0, 8'h21);
        cyc(3);
        chk("rxpin", 8'h1, {7'h0, rxDmaRequestN});
        // mode 1 with trigger level four
        for (int c = 0; c < 4; c++)
            wr(c, 2, 8'h49);
        repeat (3) inj(4'h4);
        cyc(3);
        chk("rxpin", 8'h1, {7'h0, rxDmaRequestN});
        inj(4'h4);
        cyc(3);
        chk("rxpin", 8'h0, {7'h0, rxDmaRequestN});
        rc("rdata2", 2, 0, 8'h24);
        rc("rdata2", 2, 0, 8'h23);
        rc("rdata2", 2, 0, 8'h22);
        cyc(3);
        chk("rxpin", 8'h0, {7'h0, rxDmaRequestN});
        rc("rdata2", 2, 0, 8'h21);
        cyc(3);
        chk("rxpin", 8'h1, {7'h0, rxDmaRequestN});
        inj(4'h4);
        repeat (3) tick;
        cyc(3);
        chk("rxpin", 8'h1, {7'h0, rxDmaRequestN});
        tick;
        cyc(3);
        chk("rxpin", 8'h0, {7'h0, rxDmaRequestN});
        for (int c = 0; c < 4; c++)
            for (int n = 0; n < (c == 3 ? 15 : 16); n++)
                wr(c, 0, 8'h55);
        cyc(3);
        chk("txpin", 8'h0, {7'h0, txDmaRequestN});
        wr(3, 0, 8'h56);
        cyc(3);
        chk("txpin", 8'h1, {7'h0, txDmaRequestN});
        $display("test dma done");
        give_verdict;
    end
    // watchdog well beyond the few hundred cycles the tests need
    initial begin
        repeat (6000) @(posedge clk);
        miscompares++;
        give_verdict;
    end
endmodule // uart_dma_ready_tb
`default_nettype wire

// [core/uart_dma_defines.vh]
// constants for the four-channel serial controller register and dma block
// assumes it is included by bare name from core/uart_dma_ready.v
`ifndef UART_DMA_DEFINES_VH
`define UART_DMA_DEFINES_VH

// register index inside a channel (address bits 2:0)
`define REG_DATA 3'h0
`define REG_INT_ENABLE 3'h1
`define REG_IDENT_FIFO 3'h2
`define REG_LINE_CTRL 3'h3
`define REG_MODEM_CTRL 3'h4
`define REG_LINE_STATUS 3'h5
`define REG_MODEM_STATUS 3'h6
`define REG_SCRATCH 3'h7

// interrupt enable bit positions
`define IE_RX_DATA 0
`define IE_TX_EMPTY 1
`define IE_LINE_ERR 2
`define IE_MODEM 3

// fifo control bit positions
`define FC_ENABLE 0
`define FC_DMA_MODE 3
`define FC_TRIG_LO 6

// modem control bit positions
`define MC_DTR 0
`define MC_RTS 1

// modem input bit positions inside one channel nibble
`define MI_CTS 0
`define MI_DSR 1
`define MI_RI 2
`define MI_DCD 3

// interrupt identity codes, bit 0 set means nothing pending
`define ID_NONE 4'h1
`define ID_LINE_ERR 4'h6
`define ID_RX_DATA 4'h4
`define ID_TIMEOUT 4'hc
`define ID_TX_EMPTY 4'h2
`define ID_MODEM 4'h0

// fifo geometry and timeout
`define FIFO_DEPTH 5'h10
`define TIMEOUT_CHARS 3'h4

// receive trigger levels for fifo control bits 7:6
`define TRIG_0 5'h01
`define TRIG_1 5'h04
`define TRIG_2 5'h08
`define TRIG_3 5'h0e

`endif

// [core/uart_dma_ready.v]
// register file, interrupt sources and dma request pins of four channels
// assumes fifos, baud logic and shifters live outside and report levels;
// all inputs are synchronous to clk
`include "uart_dma_defines.vh"
`timescale 1ns/10ps
`default_nettype none

module uart_dma_ready (
    input wire clk,
    input wire rstn,
    input wire [4:0] addr,
    input wire [7:0] writeData,
    input wire writeStrobe,
    input wire readStrobe,
    output reg [7:0] readData,
    input wire [19:0] rxFifoCount,
    input wire [19:0] txFifoCount,
    input wire [31:0] rxFifoData,
    input wire [3:0] rxCharArrived,
    input wire [3:0] charTimeTick,
    input wire [15:0] lineErrorEvent,
    input wire [3:0] txShifterBusy,
    input wire [15:0] modemLevels,
    output reg [3:0] rxFifoPop,
    output reg [3:0] txFifoPush,
    output reg [7:0] txPushData,
    output reg [3:0] channelEnable,
    output reg counterRestart,
    output reg [3:0] irqOut,
    output reg [3:0] dtrN,
    output reg [3:0] rtsN,
    output reg rxDmaRequestN,
    output reg txDmaRequestN
);

    // receive trigger level from the two fifo control bits
    function [4:0] trigLevel;
        input [1:0] sel;
        begin
            case (sel)
                2'h0: trigLevel = `TRIG_0;
                2'h1: trigLevel = `TRIG_1;
                2'h2: trigLevel = `TRIG_2;
                default: trigLevel = `TRIG_3;
            endcase
        end
    endfunction

    // per-channel state
    reg [3:0] intEnable [0:3];
    reg [7:0] lineCtrl [0:3];
    reg [4:0] modemCtrl [0:3];
    reg [7:0] scratchByte [0:3];
    reg [1:0] trigSel [0:3];
    reg [3:0] lineErrSticky [0:3];
    reg [3:0] modemDelta [0:3];
    reg [3:0] modemPrev [0:3];
    reg [2:0] idleChars [0:3];
    reg [3:0] fifoEnable;
    reg [3:0] dmaMode;
    reg [3:0] txHoldingEmptyFlag;
    reg [3:0] transmitterEmptyFlag;
    reg [3:0] txEmptyIrq;
    reg [3:0] rxReqLatch;
    reg modemPrimed;

    wire [1:0] accChan = addr[4:3];
    wire [2:0] accReg = addr[2:0];

    // one-hot channel strobes; decoded here so the clocked block
    // holds only non-blocking assignments
    wire [3:0] chanHit = 4'h1 << accChan;
    wire [3:0] wrHit = writeStrobe ? chanHit : 4'h0;
    wire [3:0] rdHit = readStrobe ? chanHit : 4'h0;

    ///////////////////////////////////////////////////////////////////////
    // register map of one channel, channel number in addr[4:3]
    //   index 0: read pops receive head, write pushes transmit byte
    //   index 1: interrupt enable, low nibble only
    //   index 2: read gives interrupt identity, write is fifo control
    //   index 3: line control, first write wakes the channel
    //   index 4: modem control, five bits kept
    //   index 5: line status, read only, read clears error bits
    //   index 6: modem status, read only, read clears change bits
    //   index 7: scratch byte, plain storage
    // writes to the read-only indices are dropped without notice
    //
    // line status byte layout
    //   bit 0: receive data waiting
    //   bits 4:1: sticky error flags from the line side
    //   bit 5: holding side empty
    //   bit 6: holding side and shifter both empty
    //   bit 7: some error waiting, fifo mode only
    //
    // identity byte layout
    //   bit 0: high when nothing is pending
    //   bits 3:1: source code of the winning interrupt
    //   bits 5:4: always zero
    //   bits 7:6: copy of the fifo enable
    //
    // interrupt priority, highest first
    //   line error, receive trigger, receive timeout,
    //   holding empty, modem change
    // only the winner shows; a lower source waits its turn
    //
    // clearing of sources
    //   line error: status read or reset
    //   receive data: data read drains the fifo below trigger
    //   holding empty: identity read while it wins, data write
    //   modem change: modem status read or reset
    // a new event in the clearing cycle wins over the clear,
    // so no event is lost to a badly timed read
    //
    // request pins
    //   each channel forms its own active-low request pair
    //   the four pairs are anded onto the two shared pins
    //   so a pin goes low as soon as any channel asks
    //   mode 1 needs both fifo enable and the dma bit;
    //   with fifos off a channel always behaves as mode 0
    //
    // mode 0 behaviour
    //   receive pin low while any byte waits
    //   transmit pin low only while the fifo is empty
    //   suits single transfers per request
    //
    // mode 1 behaviour
    //   receive request latched at trigger or timeout
    //   and only dropped once the fifo runs empty,
    //   letting the far side burst several bytes
    //   transmit pin low while a slot is free
    //
    // receive timeout
    //   counts character-time ticks while data waits
    //   any arrival, read or empty fifo restarts it
    //   four ticks declare the timeout, the count then
    //   stops so it cannot wrap past the limit
    //
    // modem change detection
    //   the first cycle after reset only samples levels,
    //   so a line already active does not look like a change
    //   the ring input flags its trailing edge only
    //
    // reset behaviour
    //   every channel idle until line control is written
    //   modem outputs parked at their inactive high level
    //   holding-empty flags set, error flags clear
    //   counter restart pulses for one cycle after release
    //
    // limitations
    //   fifo storage, shifters and baud logic sit outside;
    //   this block only sees their fill levels and pulses
    //   pops and pushes are one-cycle pulses, one per access
    //   read data stands for exactly one cycle, zero otherwise
    //   the holding-empty flag is held off for the push cycle
    //   because the outside count lags the push by one edge
    //
    // trade-offs
    //   all outputs are registered for clean timing, which
    //   puts one cycle between a level change and its pin;
    //   the mode 1 receive latch adds a second cycle
    //   decoding stays combinational so the register bus
    //   never waits

    ///////////////////////////////////////////////////////////////////////
    // combinational view: status bytes, interrupt identity, requests
    reg [31:0] lineStatusAll;
    reg [31:0] identAll;
    reg [3:0] pendAny;
    reg [3:0] rxReqN;
    reg [3:0] txReqN;
    reg [3:0] timedOut;
    reg [4:0] rxLvl;
    reg [4:0] txLvl;
    reg [3:0] idCode;
    integer i;

    always @* begin
        lineStatusAll = 32'h0;
        identAll = 32'h0;
        pendAny = 4'h0;
        rxReqN = 4'hf;
        txReqN = 4'hf;
        timedOut = 4'h0;
        rxLvl = 5'h0;
        txLvl = 5'h0;
        idCode = `ID_NONE;
        for (i = 0; i < 4; i = i + 1) begin
            rxLvl = rxFifoCount[i*5 +: 5];
            txLvl = txFifoCount[i*5 +: 5];
            timedOut[i] = (idleChars[i] == `TIMEOUT_CHARS);
            lineStatusAll[i*8 +: 8] = {fifoEnable[i] & |lineErrSticky[i],
                transmitterEmptyFlag[i], txHoldingEmptyFlag[i],
                lineErrSticky[i], rxLvl != 5'h0};
            // priority: line error, receive, holding empty, modem
            if (intEnable[i][`IE_LINE_ERR] && |lineErrSticky[i])
                idCode = `ID_LINE_ERR;
            else if (intEnable[i][`IE_RX_DATA] && (fifoEnable[i] ?
                    rxLvl >= trigLevel(trigSel[i]) : rxLvl != 5'h0))
                idCode = `ID_RX_DATA;
            else if (intEnable[i][`IE_RX_DATA] && timedOut[i])
                idCode = `ID_TIMEOUT;
            else if (intEnable[i][`IE_TX_EMPTY] && txEmptyIrq[i])
                idCode = `ID_TX_EMPTY;
            else if (intEnable[i][`IE_MODEM] && |modemDelta[i])
                idCode = `ID_MODEM;
            else
                idCode = `ID_NONE;
            pendAny[i] = ~idCode[0];
            // bits 4-5 fixed zero, 6-7 follow fifo enable
            identAll[i*8 +: 8] = {fifoEnable[i], fifoEnable[i], 2'h0,
                idCode};
            // mode 1 only when fifos on and dma bit set
            if (fifoEnable[i] && dmaMode[i]) begin
                rxReqN[i] = ~rxReqLatch[i];
                txReqN[i] = ~(txLvl < `FIFO_DEPTH);
            end else begin
                rxReqN[i] = ~(rxLvl != 5'h0);
                txReqN[i] = ~(txLvl == 5'h0);
            end
        end
    end

    ///////////////////////////////////////////////////////////////////////
    // read mux, sampled in the strobe cycle and shown one cycle later
    reg [7:0] next_readData;
    reg [7:0] selStatus;

    always @* begin
        selStatus = lineStatusAll[accChan*8 +: 8];
        case (accReg)
            `REG_DATA: next_readData = rxFifoData[accChan*8 +: 8];
            `REG_INT_ENABLE: next_readData = {4'h0, intEnable[accChan]};
            `REG_IDENT_FIFO: next_readData = identAll[accChan*8 +: 8];
            `REG_LINE_CTRL: next_readData = lineCtrl[accChan];
            `REG_MODEM_CTRL: next_readData = {3'h0, modemCtrl[accChan]};
            `REG_LINE_STATUS: next_readData = selStatus;
            `REG_MODEM_STATUS: next_readData = {
                modemLevels[accChan*4 +: 4], modemDelta[accChan]};
            `REG_SCRATCH: next_readData = scratchByte[accChan];
            default: next_readData = 8'h0;
        endcase
    end

    ///////////////////////////////////////////////////////////////////////
    // all state; reset puts every channel idle with counters restarted
    integer c;

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            readData <= 8'h0;
            rxFifoPop <= 4'h0;
            txFifoPush <= 4'h0;
            txPushData <= 8'h0;
            channelEnable <= 4'h0;
            counterRestart <= 1'b1;
            irqOut <= 4'h0;
            dtrN <= 4'hf;
            rtsN <= 4'hf;
            rxDmaRequestN <= 1'b1;
            txDmaRequestN <= 1'b1;
            fifoEnable <= 4'h0;
            dmaMode <= 4'h0;
            txHoldingEmptyFlag <= 4'hf;
            transmitterEmptyFlag <= 4'hf;
            txEmptyIrq <= 4'h0;
            rxReqLatch <= 4'h0;
            modemPrimed <= 1'b0;
            for (c = 0; c < 4; c = c + 1) begin
                intEnable[c] <= 4'h0;
                lineCtrl[c] <= 8'h0;
                modemCtrl[c] <= 5'h0;
                scratchByte[c] <= 8'h0;
                trigSel[c] <= 2'h0;
                lineErrSticky[c] <= 4'h0;
                modemDelta[c] <= 4'h0;
                modemPrev[c] <= 4'h0;
                idleChars[c] <= 3'h0;
            end
        end else begin
            counterRestart <= 1'b0;
            modemPrimed <= 1'b1;
            readData <= readStrobe ? next_readData : 8'h0;
            txPushData <= writeData;
            irqOut <= pendAny;
            rxDmaRequestN <= &rxReqN;
            txDmaRequestN <= &txReqN;
            for (c = 0; c < 4; c = c + 1) begin
                rxFifoPop[c] <= rdHit[c] && accReg == `REG_DATA;
                txFifoPush[c] <= wrHit[c] && accReg == `REG_DATA;
                dtrN[c] <= ~modemCtrl[c][`MC_DTR];
                rtsN[c] <= ~modemCtrl[c][`MC_RTS];
                // register writes
                if (wrHit[c]) begin
                    case (accReg)
                        `REG_INT_ENABLE: intEnable[c] <= writeData[3:0];
                        `REG_IDENT_FIFO: begin
                            fifoEnable[c] <= writeData[`FC_ENABLE];
                            dmaMode[c] <= writeData[`FC_DMA_MODE];
                            trigSel[c] <= writeData[`FC_TRIG_LO +: 2];
                        end
                        `REG_LINE_CTRL: begin
                            lineCtrl[c] <= writeData;
                            channelEnable[c] <= 1'b1;
                        end
                        `REG_MODEM_CTRL: modemCtrl[c] <= writeData[4:0];
                        `REG_SCRATCH: scratchByte[c] <= writeData;
                        default: ;
                    endcase
                end
                // error flags: a new event beats a same-cycle status read
                lineErrSticky[c] <= ((rdHit[c] &&
                    accReg == `REG_LINE_STATUS) ?
                    4'h0 : lineErrSticky[c]) | lineErrorEvent[c*4 +: 4];
                // holding empty waits out the push so it does not bounce
                if (wrHit[c] && accReg == `REG_DATA) begin
                    txHoldingEmptyFlag[c] <= 1'b0;
                    transmitterEmptyFlag[c] <= 1'b0;
                end else if (!txFifoPush[c]) begin
                    txHoldingEmptyFlag[c] <= txFifoCount[c*5 +: 5] == 5'h0;
                    transmitterEmptyFlag[c] <= txFifoCount[c*5 +: 5] == 5'h0
                        && !txShifterBusy[c];
                end
                // holding-empty interrupt: set on rising flag or on enable
                if ((!txHoldingEmptyFlag[c] && !txFifoPush[c] &&
                        txFifoCount[c*5 +: 5] == 5'h0) ||
                    (wrHit[c] && accReg == `REG_INT_ENABLE &&
                        writeData[`IE_TX_EMPTY] &&
                        !intEnable[c][`IE_TX_EMPTY] &&
                        txHoldingEmptyFlag[c]))
                    txEmptyIrq[c] <= 1'b1;
                else if ((wrHit[c] && accReg == `REG_DATA) ||
                    (rdHit[c] && accReg == `REG_IDENT_FIFO &&
                        identAll[c*8 +: 4] == `ID_TX_EMPTY))
                    txEmptyIrq[c] <= 1'b0;
                // modem deltas; first cycle after reset only samples
                modemPrev[c] <= modemLevels[c*4 +: 4];
                modemDelta[c] <= ((rdHit[c] &&
                    accReg == `REG_MODEM_STATUS) ?
                    4'h0 : modemDelta[c]) | ({4{modemPrimed}} & {
                    modemPrev[c][`MI_DCD] ^ modemLevels[c*4 + `MI_DCD],
                    modemPrev[c][`MI_RI] & ~modemLevels[c*4 + `MI_RI],
                    modemPrev[c][`MI_DSR] ^ modemLevels[c*4 + `MI_DSR],
                    modemPrev[c][`MI_CTS] ^ modemLevels[c*4 + `MI_CTS]
                    });
                // character timeout counter, only while data waits
                if (rxCharArrived[c] || rxFifoCount[c*5 +: 5] == 5'h0 ||
                        (rdHit[c] && accReg == `REG_DATA))
                    idleChars[c] <= 3'h0;
                else if (charTimeTick[c] && !timedOut[c])
                    idleChars[c] <= idleChars[c] + 3'h1;
                // mode 1 receive latch: set at trigger or timeout
                if (rxFifoCount[c*5 +: 5] >= trigLevel(trigSel[c]) ||
                        timedOut[c])
                    rxReqLatch[c] <= 1'b1;
                else if (rxFifoCount[c*5 +: 5] == 5'h0)
                    rxReqLatch[c] <= 1'b0;
            end
        end
    end

endmodule // uart_dma_ready

`default_nettype wire
